// >>> rtl/srh_host.sv
// host sequencer for a 256 x 4 strobe-latched static ram
// assumes user requests and ram read pins are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module srh_host (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    // user side
    input  wire logic                        reqValid,
    input  wire logic                        reqWrite,
    input  wire logic [srh_pkg::ADDR_W-1:0]  reqAddr,
    input  wire logic [srh_pkg::DATA_W-1:0]  reqData,
    output logic                             reqReady,
    output logic                             rspValid,
    output logic                             rspRefused,
    output logic [srh_pkg::DATA_W-1:0]       rspData,
    input  wire logic                        retentionMode,
    // ram pins
    output logic                             cycleStrobeN,
    output logic                             storedChipSelectN,
    output logic                             levelChipSelectN,
    output logic                             writeEnableN,
    output logic [srh_pkg::ADDR_W-1:0]       addrPins,
    output logic [srh_pkg::DATA_W-1:0]       writeDataBits,
    input  wire logic [srh_pkg::DATA_W-1:0]  readDataBits,
    output logic [srh_pkg::DATA_W-1:0]       sharedDataOut,
    output logic                             sharedDataOeN
);

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    srh_pkg::srh_state_t       state;
    srh_pkg::srh_state_t       next_state;
    logic                      opWrite;
    logic [srh_pkg::DATA_W-1:0] opData;
    logic                      accept;
    logic                      refuse;
    logic                      inCycle;

    srh_timer_if tmrIf ();

    srh_phase_timer u_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tmr     (tmrIf.timer)
    );

    // a write offered in retention is answered but never started
    assign accept = (state == srh_pkg::IDLE) && reqValid;
    assign refuse = accept && reqWrite && retentionMode;

    // next phase; every phase but IDLE lasts until the timer expires
    always_comb
    begin
        next_state = state;
        unique case (state)
            srh_pkg::POWERUP:
                if (tmrIf.expired)
                    next_state = srh_pkg::IDLE;
            srh_pkg::IDLE:
                if (accept && !refuse)
                    next_state = srh_pkg::SETUP;
            srh_pkg::SETUP:
                if (tmrIf.expired)
                    next_state = srh_pkg::ACTIVE;
            srh_pkg::ACTIVE:
                if (tmrIf.expired)
                    next_state = srh_pkg::RECOVER;
            srh_pkg::RECOVER:
                if (tmrIf.expired)
                    next_state = srh_pkg::IDLE;
        endcase
    end

    // timer reloads on every change of phase
    always_comb
    begin
        tmrIf.load  = (next_state != state);
        tmrIf.count = srh_pkg::CNT_ONE;
        unique case (next_state)
            srh_pkg::SETUP:
                tmrIf.count = srh_pkg::AS_CYC;
            srh_pkg::ACTIVE:
                tmrIf.count = opWrite ? srh_pkg::WRITE_LOW_CYC
                                      : srh_pkg::READ_LOW_CYC;
            srh_pkg::RECOVER:
                tmrIf.count = srh_pkg::HIGH_CYC;
            default:
                tmrIf.count = srh_pkg::CNT_ONE;
        endcase
    end

    assign inCycle = (next_state == srh_pkg::SETUP) ||
                     (next_state == srh_pkg::ACTIVE) ||
                     (next_state == srh_pkg::RECOVER);

    // phase register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            state <= srh_pkg::POWERUP;
        else
            state <= next_state;
    end

    // operation latched at acceptance, held for the whole cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            opWrite <= 1'b0;
            opData  <= '0;
        end
        else if (accept)
        begin
            opWrite <= reqWrite;
            opData  <= reqData;
        end
    end

    // -------------------------------------------------------------
    // ram pins
    // -------------------------------------------------------------

    // address held from set-up through recovery for hold time
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            addrPins <= '0;
        else if (accept)
            addrPins <= reqAddr;
    end

    // strobe stays high through power-up and between cycles
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            cycleStrobeN <= 1'b1;
        else
            cycleStrobeN <= (next_state != srh_pkg::ACTIVE);
    end

    // stored select must be settled before strobe falls
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            storedChipSelectN <= 1'b1;
        else
            storedChipSelectN <= !inCycle;
    end

    // level select falls a cycle after strobe, well inside output enable
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            levelChipSelectN <= 1'b1;
        else
            levelChipSelectN <= !((state == srh_pkg::ACTIVE) &&
                                  (next_state == srh_pkg::ACTIVE));
    end

    // write enable low only inside strobe and level select low
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            writeEnableN <= 1'b1;
        else
            writeEnableN <= !((state == srh_pkg::ACTIVE) &&
                              (next_state == srh_pkg::ACTIVE) &&
                              opWrite && !retentionMode);
    end

    // write data driven through recovery to cover data hold
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            writeDataBits <= '0;
            sharedDataOut <= '0;
            sharedDataOeN <= 1'b1;
        end
        else
        begin
            writeDataBits <= opData;
            sharedDataOut <= opData;
            // never drive the joined pins on a read, the ram does then;
            // a write withdrawn for retention reads, so let go of them too
            sharedDataOeN <= !(opWrite && inCycle &&
                               (next_state != srh_pkg::SETUP) &&
                               !(retentionMode &&
                                 (next_state == srh_pkg::ACTIVE)));
        end
    end

    // -------------------------------------------------------------
    // user side answers
    // -------------------------------------------------------------

    // ready only in idle; a held request is taken at once
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            reqReady <= 1'b0;
        else
            reqReady <= (next_state == srh_pkg::IDLE) && !accept;
    end

    // answer pulses at the end of the strobe-low phase or on refusal
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rspValid   <= 1'b0;
            rspRefused <= 1'b0;
            rspData    <= '0;
        end
        else
        begin
            rspValid   <= refuse ||
                          ((state == srh_pkg::ACTIVE) && tmrIf.expired);
            rspRefused <= refuse;
            if ((state == srh_pkg::ACTIVE) && tmrIf.expired && !opWrite)
                rspData <= readDataBits;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    localparam int RSP_MIN = 9;
    localparam int RSP_MAX = 17;

    write_pulse_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) !writeEnableN |->
        !cycleStrobeN && !levelChipSelectN)
        else $error("write enable low outside strobe and level select");

    pulse_width_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $fell(writeEnableN) |-> (!writeEnableN) [*8])
        else $error("write pulse shorter than eight cycles");

    level_after_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $fell(cycleStrobeN) |->
        levelChipSelectN ##1 !levelChipSelectN)
        else $error("level select not one cycle after strobe");

    retention_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) retentionMode |=> writeEnableN)
        else $error("write enable asserted during retention");

    powerup_hold_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $rose(rst_b) |-> cycleStrobeN [*8] ##1 !reqReady)
        else $error("strobe or ready moved during power-up hold");

    addr_setup_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $fell(cycleStrobeN) |->
        $stable(addrPins) && !$past(storedChipSelectN))
        else $error("address or stored select not set up at strobe fall");

    addr_hold_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $rose(cycleStrobeN) |->
        $stable(addrPins) && !storedChipSelectN)
        else $error("address or stored select released at strobe rise");

    answer_time_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $fell(cycleStrobeN) |->
        ##[RSP_MIN:RSP_MAX] rspValid)
        else $error("no answer after strobe fall");

    shared_drive_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b) !sharedDataOeN |-> opWrite &&
        !storedChipSelectN && (!writeEnableN || levelChipSelectN))
        else $error("shared data driven outside a write or against the ram");

endmodule : srh_host

`default_nettype wire

// >>> rtl/srh_phase_timer.sv
// down counter timing each phase of a ram cycle
// assumes load is a one-cycle pulse and count is at least one
`timescale 1ns/1ps
`default_nettype none

module srh_phase_timer (
    input  wire logic  ref_clk,
    input  wire logic  rst_b,
    srh_timer_if.timer tmr
);

    logic [srh_pkg::CNT_W-1:0] cnt;

    // reset value covers the power-up hold, no load needed
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            cnt <= srh_pkg::SETTLE_CYC - srh_pkg::CNT_ONE;
        else if (tmr.load)
            cnt <= tmr.count - srh_pkg::CNT_ONE;
        else if (cnt != srh_pkg::CNT_ZERO)
            cnt <= cnt - srh_pkg::CNT_ONE;
    end

    // expired on the last cycle of the loaded interval
    assign tmr.expired = (cnt == srh_pkg::CNT_ZERO);

endmodule : srh_phase_timer

`default_nettype wire

// >>> rtl/srh_pkg.sv
// constants shared by the strobe-latched ram host controller
// assumes a 50 MHz ref_clk; all pin times are rounded up to whole cycles
`default_nettype none

package srh_pkg;

    // -------------------------------------------------------------
    // widths of the memory being driven
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;                  // 256 words
    localparam int DATA_W = 4;                  // four bits per word
    localparam int CNT_W  = 6;

    // -------------------------------------------------------------
    // pin timing in ns, slowest grade, and derived cycle counts
    // -------------------------------------------------------------
    localparam int PERIOD_NS  = 20;
    localparam int AS_NS      = 25;             // address set-up
    localparam int WP_NS      = 165;            // strobe/write pulse low
    localparam int ACS_NS     = 300;            // access from strobe
    localparam int ST_HIGH_NS = 165;            // strobe high width
    localparam int SETTLE_NS  = 1000;           // power-up settle hold

    localparam logic [CNT_W-1:0] AS_CYC =
        CNT_W'((AS_NS + PERIOD_NS - 1) / PERIOD_NS);
    localparam logic [CNT_W-1:0] WRITE_LOW_CYC =
        CNT_W'((WP_NS + PERIOD_NS - 1) / PERIOD_NS);
    // one cycle beyond access time so the sample lands on settled data
    localparam logic [CNT_W-1:0] READ_LOW_CYC =
        CNT_W'((ACS_NS + PERIOD_NS - 1) / PERIOD_NS + 1);
    localparam logic [CNT_W-1:0] HIGH_CYC =
        CNT_W'((ST_HIGH_NS + PERIOD_NS - 1) / PERIOD_NS);
    localparam logic [CNT_W-1:0] SETTLE_CYC =
        CNT_W'((SETTLE_NS + PERIOD_NS - 1) / PERIOD_NS);

    localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    // -------------------------------------------------------------
    // cycle sequencer states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        POWERUP,
        IDLE,
        SETUP,
        ACTIVE,
        RECOVER
    } srh_state_t;

endpackage : srh_pkg

`default_nettype wire

// >>> rtl/srh_timer_if.sv
// interval timer link between sequencer and its phase timer
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
`default_nettype none

interface srh_timer_if;
    logic                     load;
    logic [srh_pkg::CNT_W-1:0] count;
    logic                     expired;

    modport ctrl  (output load, output count, input expired);
    modport timer (input load, input count, output expired);
endinterface : srh_timer_if

`default_nettype wire

// >>> test/srh_host_tb_top.sv
// self-checking bench for the strobe-latched ram host sequencer
// assumes the ram model sits on the joined data pins
`timescale 1ns/1ps
`default_nettype none

module srh_host_tb_top;
    // ------------
    // pins and state
    // ------------
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       reqValid = 1'b0;
    logic       reqWrite = 1'b0;
    logic [7:0] reqAddr = 8'h00;
    logic [3:0] reqData = 4'h0;
    logic       retentionMode = 1'b0;
    logic       reqReady, rspValid, rspRefused, misuse;
    logic       cycleStrobeN, storedChipSelectN, levelChipSelectN;
    logic       writeEnableN, sharedDataOeN;
    logic [7:0] addrPins;
    logic [3:0] rspData, writeDataBits, sharedDataOut, ramQ, dataBus;
    logic [7:0] addrs [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
    logic       refd;
    int         lat, sFall, lFall;
    int         n_mismatch = 0;
    int         n_compared = 0;

    always #10 ref_clk = ~ref_clk;
    // joined pins: host drives while its enable is low
    assign dataBus = !sharedDataOeN ? sharedDataOut : ramQ;

    srh_host srh_host_i (
        .ref_clk, .rst_b, .reqValid, .reqWrite, .reqAddr, .reqData,
        .reqReady, .rspValid, .rspRefused, .rspData, .retentionMode,
        .cycleStrobeN, .storedChipSelectN, .levelChipSelectN,
        .writeEnableN, .addrPins, .writeDataBits,
        .readDataBits (dataBus),
        .sharedDataOut, .sharedDataOeN
    );
    srh_ram_model srh_ram_model_i (
        .strobeN    (cycleStrobeN),
        .storedSelN (storedChipSelectN),
        .levelSelN  (levelChipSelectN),
        .writeEnN   (writeEnableN),
        .addr       (addrPins),
        .dataIn     (dataBus),
        .hostDrives (!sharedDataOeN),
        .retention  (retentionMode),
        .dataOut    (ramQ),
        .misuse     (misuse)
    );

    // ------------
    // shared tasks
    // ------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one request from offer to answer, timing strobe and level select
    task automatic do_op(input logic w, input logic [7:0] a,
                         input logic [3:0] d, input int retAt);
        @(posedge ref_clk);
        #1;
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqData <= d;
        retentionMode <= (retAt == 0);
        while (reqReady !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        reqValid <= 1'b0;
        lat = 1;
        sFall = 0;
        lFall = 0;
        while (rspValid !== 1'b1 && lat < 40)
        begin
            if (lat == retAt)
                retentionMode <= 1'b1;
            if (cycleStrobeN === 1'b0 && sFall == 0)
                sFall = lat;
            if (levelChipSelectN === 1'b0 && lFall == 0)
                lFall = lat;
            @(posedge ref_clk);
            #1;
            lat++;
        end
        refd = rspRefused;
        if (lat > 1)
            retentionMode <= 1'b0;
    endtask : do_op

    task automatic op_chk(input logic w, input logic [3:0] d);
        chk(8'(lat), w ? 8'h0c : 8'h13, "answer latency");
        chk(8'(sFall), 8'h03, "strobe fall");
        chk(8'(lFall), 8'h04, "level select fall");
        chk(refd, 8'h00, "refused flag");
        chk(w ? writeDataBits : rspData, d, "data");
    endtask : op_chk

    // ------------
    // scenarios
    // ------------
    task automatic t_powerup();
        logic bad;
        bad = 1'b0;
        for (int i = 1; i < 50; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (cycleStrobeN !== 1'b1 || reqReady !== 1'b0)
                bad = 1'b1;
        end
        chk(bad, 8'h00, "strobe moved in hold");
        @(posedge ref_clk);
        #1;
        chk(reqReady, 8'h01, "ready after hold");
        $display("test powerup done");
    endtask : t_powerup

    // boundary and alternating-bit addresses written, then each read twice
    task automatic t_data();
        for (int k = 0; k < 4; k++)
        begin
            do_op(1'b1, addrs[k], 4'(k * 5 + 3), -1);
            op_chk(1'b1, 4'(k * 5 + 3));
        end
        for (int k = 0; k < 8; k++)
        begin
            do_op(1'b0, addrs[k % 4], 4'h0, -1);
            op_chk(1'b0, 4'(k % 4 * 5 + 3));
        end
        chk(misuse, 8'h00, "ram misuse");
        $display("test data done");
    endtask : t_data

    task automatic t_retention();
        do_op(1'b1, 8'h5a, 4'h0, 0);
        chk(8'(lat), 8'h01, "refusal latency");
        chk(refd, 8'h01, "refused flag");
        // retention rises once strobe is down: no write may land
        do_op(1'b1, 8'h5a, 4'h0, 3);
        chk(8'(lat), 8'h0c, "withdrawn write latency");
        chk(refd, 8'h00, "mid-cycle refused flag");
        do_op(1'b0, 8'h5a, 4'h0, -1);
        chk(rspData, 8'h0d, "word kept");
        chk(misuse, 8'h00, "ram misuse");
        $display("test retention done");
    endtask : t_retention

    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1;
        rst_b <= 1'b1;
        t_powerup();
        t_data();
        t_retention();
        test_done();
    end

    // about 420 cycles expected; 5000 leaves ample margin
    initial
    begin
        #100000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end
endmodule : srh_host_tb_top

`default_nettype wire

// >>> test/srh_ram_model.sv
// behavioural 256 x 4 strobe-latched ram, joined data pin variant
// assumes host pins change just after ref_clk edges
`timescale 1ns/1ps
`default_nettype none

module srh_ram_model #(
    parameter int ACCESS_NS = srh_pkg::ACS_NS
) (
    input  wire logic       strobeN,
    input  wire logic       storedSelN,
    input  wire logic       levelSelN,
    input  wire logic       writeEnN,
    input  wire logic [7:0] addr,
    input  wire logic [3:0] dataIn,
    input  wire logic       hostDrives,
    input  wire logic       retention,
    output logic      [3:0] dataOut,
    output logic            misuse
);
    // ------------
    // cells and latches
    // ------------
    logic [3:0] mem [256];
    logic [7:0] addrLat;
    logic       selLat = 1'b1;
    logic [3:0] outReg = 4'h0;
    logic       outOn;
    logic       writing;

    // address and stored select latch at strobe fall; the output latch is disturbed too
    always @(negedge strobeN)
    begin
        addrLat = addr;
        selLat  = storedSelN;
        outReg  = ~outReg;
    end

    // sensed word shows only once the access time has run
    always @(negedge strobeN)
    begin
        #(ACCESS_NS);
        if (!strobeN)
            outReg = mem[addrLat];
    end

    // output register reloads as strobe rises
    always @(posedge strobeN)
        outReg = mem[addrLat];

    // ------------
    // write path and buffers
    // ------------
    // level select is never latched, so it gates both paths directly
    assign writing = !strobeN && !selLat && !levelSelN
                     && !writeEnN;
    always @*
        if (writing)
            mem[addrLat] = dataIn;
    assign outOn = !selLat && !levelSelN && writeEnN;
    // no pull-up: a floating bus shows the inverse, never the old word
    assign dataOut = outOn ? outReg : ~outReg;

    // judged after the edge settles so same-edge pin moves never trip it
    initial
        misuse = 1'b0;
    always @*
    begin
        #1;
        if ((writing && retention) || (!writeEnN && strobeN)
            || (outOn && hostDrives))
            misuse = 1'b1;
    end
endmodule : srh_ram_model

`default_nettype wire
